// file: tb_top.sv
// Purpose: Self-checking bench for the serial status and control block.
// Assumes: Divisor 3, so each line bit lasts four clocks.
// Notes:   Reads and sent chars are queued and compared by monitors.
`timescale 1ns/1ps

module tb_top;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [3:0]  address = 4'h0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [3:0]  byteenable = 4'h0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        serial_tx_pin;
  logic        serial_tx_oe;
  logic        serial_rx_pin;
  logic        tx_irq;
  logic        rx_irq;
  logic        got;
  logic [7:0]  got_char;
  int          low_run;
  int          failures = 0;
  int          num_checks = 0;
  int          txp = 0;
  int          rxp = 0;
  int          frames = 0;
  int          n0;
  logic [31:0] rd;
  logic [63:0] m;
  logic [7:0]  c;
  logic [63:0] exp_q[$];
  logic [7:0]  chr_q[$];
  logic [7:0]  sent[$];
  logic [1:0]  tsel[3] = '{2'b00, 2'b10, 2'b01};
  int          tev[3] = '{5, 2, 1};
  int          rev[4] = '{4, 4, 1, 1};

  // Clock
  always #5 clk = ~clk;

  usc_top dut (.clk, .rstn, .address, .read, .write, .byteenable, .writedata, .readdata,
    .waitrequest, .serial_tx_pin, .serial_tx_oe, .serial_rx_pin, .tx_irq, .rx_irq);

  usc_remote #(.BIT_CYCLES(4)) u_rem (.clk, .line_in(serial_tx_pin), .line_oe(serial_tx_oe),
    .line_out(serial_rx_pin), .got, .got_char, .low_run);

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One access, held until waitrequest is low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    byteenable <= 4'hF;
    read <= !wr;
    write <= wr;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic rdq(input logic [3:0] a, input logic [31:0] e, input logic [31:0] mk);
    exp_q.push_back({mk, e});
    bus(1'b0, a, 32'h0000_0000);
  endtask : rdq

  function automatic logic [31:0] stat(input logic [1:0] ts, input logic inv, input logic brk,
    input logic en, input logic [1:0] rs);
    return {16'h0000, ts[1], inv, ts[0], 1'b0, brk, en, 2'b00, rs, 6'h00};
  endfunction : stat

  task automatic wait_idle;
    rd = 32'h0000_0000;
    while (rd[8] !== 1'b1) rdq(4'h0, 32'h0000_0000, 32'h0000_0000);
    repeat (4) @(posedge clk);
  endtask : wait_idle

  task automatic drain;
    while (sent.size() > 0) rdq(4'h8, {24'h0, sent.pop_front()}, 32'h0000_01FF);
    rdq(4'h0, 32'h0000_0000, 32'h0000_0003);
  endtask : drain

  task automatic rx_send(input int n);
    for (int j = 0; j < n; j++) begin
      c = 8'($urandom);
      if (j < 4) sent.push_back(c);
      u_rem.send(c, 1'b1);
    end
    repeat (8) @(posedge clk);
  endtask : rx_send

  // Read monitor and event counters
  always @(negedge clk) begin
    txp += (tx_irq === 1'b1);
    rxp += (rx_irq === 1'b1);
    if (read === 1'b1 && waitrequest === 1'b0) begin
      m = exp_q.pop_front();
      check("readdata", readdata & m[63:32], m[31:0] & m[63:32]);
    end
  end

  // Frames decoded by the remote end
  always @(posedge clk) begin
    if (got === 1'b1) begin
      frames++;
      check("tx char", {24'h0, got_char}, {24'h0, chr_q.pop_front()});
    end
  end

  task automatic print_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    print_verdict;
  end

  initial begin
    void'($urandom(63));
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    // Reset values, an unmapped word, then divisor 3
    rdq(4'h0, 32'h0000_0110, 32'hFFFF_FFFF);
    rdq(4'hC, 32'h0000_0363, 32'hFFFF_FFFF);
    rdq(4'h6, 32'h0000_0000, 32'hFFFF_FFFF);
    // Idle level per encode and invert, owner off
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 4'hC, {15'h0, i[1], 16'h0003});
      bus(1'b1, 4'h0, stat(2'b00, i[0], 1'b0, 1'b0, 2'b00));
      repeat (4) @(negedge clk);
      check("idle level", {31'h0, serial_tx_pin}, {31'h0, i[1] == i[0]});
    end
    bus(1'b1, 4'hC, 32'h0000_0003);
    // Six chars into four slots per event mode
    foreach (tev[k]) begin
      bus(1'b1, 4'h0, stat(tsel[k], 1'b0, 1'b0, 1'b1, 2'b00));
      txp = 0;
      for (int n = 0; n < 6; n++) begin
        c = 8'($urandom);
        if (n < 5) chr_q.push_back(c);
        bus(1'b1, 4'h4, {24'h0, c});
      end
      rdq(4'h0, 32'h0000_0200, 32'h0000_0300);
      wait_idle;
      check("tx events", txp, tev[k]);
      rdq(4'h0, 32'h0000_0100, 32'h0000_0300);
    end
    // Break frame eats one char, then self-clears
    bus(1'b1, 4'h0, stat(2'b00, 1'b0, 1'b1, 1'b1, 2'b00));
    chr_q.push_back(8'h00);
    bus(1'b1, 4'h4, 32'h0000_00A5);
    wait_idle;
    check("low run", low_run, 32'd52);
    rdq(4'h0, 32'h0000_0500, 32'h0000_0F00);
    // Disabling mid frame drops it and the queued chars
    n0 = frames;
    for (int n = 0; n < 3; n++) bus(1'b1, 4'h4, 32'h0000_0055);
    bus(1'b1, 4'h0, stat(2'b00, 1'b0, 1'b0, 1'b0, 2'b00));
    rdq(4'h0, 32'h0000_0100, 32'h0000_0700);
    bus(1'b1, 4'h0, stat(2'b00, 1'b0, 1'b0, 1'b1, 2'b00));
    repeat (150) @(posedge clk);
    check("stray frames", frames, n0);
    // Receive event thresholds per selector
    foreach (rev[k]) begin
      bus(1'b1, 4'h0, stat(2'b00, 1'b0, 1'b0, 1'b1, k[1:0]));
      rxp = 0;
      rx_send(4);
      check("rx events", rxp, rev[k]);
      drain;
    end
    // Fifth char overruns; sticky until cleared; framing follows the head
    rx_send(5);
    rdq(4'h0, 32'h0000_0003, 32'h0000_0003);
    bus(1'b1, 4'h0, stat(2'b00, 1'b0, 1'b0, 1'b1, 2'b00));
    rdq(4'h0, 32'h0000_0001, 32'h0000_0003);
    drain;
    u_rem.send(8'h3C, 1'b0);
    repeat (8) @(posedge clk);
    rdq(4'h0, 32'h0000_0005, 32'h0000_0007);
    rdq(4'h8, 32'h0000_013C, 32'h0000_01FF);
    print_verdict;
  end
endmodule : tb_top

// file: usc_chk.sv
// Purpose: Port assertions for the serial status and control block.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound to usc_top at the foot of this file.
`timescale 1ns/1ps

module usc_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // Register bus
  input wire logic [3:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // Line and events
  input wire logic        serial_tx_pin,
  input wire logic        serial_tx_oe,
  input wire logic        tx_irq,
  input wire logic        rx_irq
);
  logic en_w_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Last enable bit accepted by a status write
  always_ff @(posedge clk) begin
    if (!rstn) en_w_ff <= 1'b0;
    else if (write && !waitrequest && address == 4'h0 && byteenable[1]) en_w_ff <= writedata[10];
  end

  property p_wait_one;
    (read || write) && waitrequest |=> !waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("request stalled over one cycle");
  property p_wait_idle;
    !(read || write) |-> !waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("stall without a request");
  property p_oe_follow;
    write && !waitrequest && address == 4'h0 && byteenable[1] |-> ##[1:2] serial_tx_oe == en_w_ff;
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("pin owner off enable");
  property p_quiet_off;
    !serial_tx_oe && !$past(serial_tx_oe) |-> !tx_irq;
  endproperty
  a_quiet_off: assert property (p_quiet_off) else $error("tx event while disabled");
  property p_stat_bits;
    read && !waitrequest && address == 4'h0
      |-> readdata[31:16] == 16'h0000 && !readdata[12] && !(readdata[9] && readdata[8]);
  endproperty
  a_stat_bits: assert property (p_stat_bits) else $error("bad status flags");
  property p_unmapped;
    read && !waitrequest && address[1:0] != 2'b00 |-> readdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_tx_pulse;
    tx_irq |=> !tx_irq;
  endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("tx event too long");
  property p_rx_pulse;
    rx_irq |=> !rx_irq;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("rx event too long");
  property p_reset_idle;
    $rose(rstn) |-> serial_tx_pin && !serial_tx_oe && !tx_irq && !rx_irq;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("bad reset state");
endmodule : usc_chk

bind usc_top usc_chk u_chk (.clk, .rstn, .address, .read, .write, .byteenable, .writedata,
  .readdata, .waitrequest, .serial_tx_pin, .serial_tx_oe, .tx_irq, .rx_irq);

// file: usc_defines.svh
// Purpose: Register map, field positions, reset values and frame counts.
// Assumes: Byte addresses on a 32-bit Avalon-MM slave.
// Notes:   Definitions only.
`ifndef USC_DEFINES_SVH
`define USC_DEFINES_SVH

// Register byte offsets
`define USC_OFS_STAT    4'h0
`define USC_OFS_TXDATA  4'h4
`define USC_OFS_RXDATA  4'h8
`define USC_OFS_CFG     4'hC

// Status/control and CFG field positions
`define USC_B_TXISEL1   15
`define USC_B_TXINV     14
`define USC_B_TXISEL0   13
`define USC_B_TXBRK     11
`define USC_B_TXEN      10
`define USC_B_RXISEL1   7
`define USC_B_RXISEL0   6
`define USC_B_ADDRESS_DETECT_ENABLE     5
`define USC_B_OVERRUN_ERROR_FLAG      1
`define USC_B_INFRARED_ENCODE_ENABLE      16

// Reset values
`define USC_DIV_RST     16'h0363
`define USC_RDATA_RST   32'h0000_0000

// Buffer depth and frame shapes
`define USC_FIFO_DEPTH  4
`define USC_DATA_FRAME  4'hA
`define USC_BRK_FRAME   4'hE
`define USC_RX_LAST_BIT 3'h7

`endif

// file: usc_fifo.sv
// Purpose: Four-entry character buffer with the head held in a register.
// Assumes: The caller never pushes while full unless it pops the same cycle.
// Notes:   Entries shift toward slot 0 on a pop; flush empties it.
`timescale 1ns/1ps
`include "usc_defines.svh"

module usc_fifo #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Control
  input  wire logic             flush,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] din,
  input  wire logic             pop,
  // State
  output logic      [WIDTH-1:0] dout,
  output logic      [2:0]       count,
  output logic                  full,
  output logic                  empty
);

  logic [WIDTH-1:0] mem_ff [0:`USC_FIFO_DEPTH-1];
  logic [2:0]       cnt_ff;
  logic             do_pop;
  logic [2:0]       wslot;

  // Slot the incoming character lands in
  assign do_pop = pop & (cnt_ff != 3'h0);
  assign wslot  = do_pop ? cnt_ff - 3'h1 : cnt_ff;

  // Fill level
  always_ff @(posedge clk) begin
    if (!rstn || flush) begin
      cnt_ff <= 3'h0;
    end else begin
      cnt_ff <= cnt_ff + {2'b00, push} - {2'b00, do_pop};
    end
  end

  // Storage, shifting toward the head
  always_ff @(posedge clk) begin
    for (int i = 0; i < `USC_FIFO_DEPTH; i++) begin
      if (push && wslot == 3'(i)) begin
        mem_ff[i] <= din;
      end else if (do_pop && i < `USC_FIFO_DEPTH - 1) begin
        mem_ff[i] <= mem_ff[2'(i + 1)];
      end
    end
  end

  assign dout  = mem_ff[0];
  assign count = cnt_ff;
  assign full  = (cnt_ff == 3'(`USC_FIFO_DEPTH));
  assign empty = (cnt_ff == 3'h0);

endmodule : usc_fifo

// file: usc_pkg.sv
// Purpose: Types shared by the serial status and control block.
// Assumes: Nothing beyond the defines header.
// Notes:   Binary state codes written out.
package usc_pkg;

  // Transmit engine states
  typedef enum logic [0:0] {
    USC_TX_IDLE  = 1'b0,
    USC_TX_SHIFT = 1'b1
  } usc_tx_state_type;

  // Receive engine states
  typedef enum logic [1:0] {
    USC_RX_IDLE  = 2'b00,
    USC_RX_START = 2'b01,
    USC_RX_DATA  = 2'b10,
    USC_RX_STOP  = 2'b11
  } usc_rx_state_type;

endpackage : usc_pkg

// file: usc_remote.sv
// Purpose: Remote serial transceiver on the far end of the line.
// Assumes: 8 data bits, one stop bit, idle high, plain polarity.
// Notes:   Frames cut off by loss of pin ownership are not reported.
`timescale 1ns/1ps

module usc_remote #(
  parameter int BIT_CYCLES = 4
) (
  // Clock
  input  wire logic       clk,
  // Line from the block
  input  wire logic       line_in,
  input  wire logic       line_oe,
  // Line to the block
  output logic            line_out,
  // Decoded frame
  output logic            got,
  output logic [7:0]      got_char,
  output int              low_run
);
  int   run = 0;
  logic ok;

  // Length of the last low stretch on the owned line
  always @(negedge clk) begin
    if (line_oe === 1'b1 && line_in === 1'b0) run++;
    else if (run != 0) begin
      low_run = run;
      run = 0;
    end
  end

  // Mid-bit sampling decoder
  initial begin
    got = 1'b0;
    line_out = 1'b1;
    forever begin
      @(negedge clk);
      if (line_oe === 1'b1 && line_in === 1'b0) begin
        ok = 1'b1;
        repeat (BIT_CYCLES / 2) @(negedge clk);
        for (int b = 0; b < 9; b++) begin
          repeat (BIT_CYCLES) @(negedge clk);
          ok &= line_oe;
          if (b < 8) got_char[b] = line_in;
        end
        got = ok;
        @(negedge clk);
        got = 1'b0;
        while (line_oe === 1'b1 && line_in === 1'b0) @(negedge clk);
      end
    end
  end

  // Send one frame, then one idle bit
  task automatic send(input logic [7:0] ch, input logic stop);
    logic [10:0] f;
    f = {1'b1, stop, ch, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk);
      line_out <= f[i];
      repeat (BIT_CYCLES - 1) @(posedge clk);
    end
  endtask : send
endmodule : usc_remote

// file: usc_top.sv
// Purpose: Status and control of an asynchronous serial transceiver.
// Assumes: Avalon-MM byte addresses; serial_rx_pin is synchronous to clk.
// Notes:   8 data bits, one stop bit, no parity; the baud divisor is in CFG.
// Function
// - Selector 10 pulses the transmit event when a load into the shifter empties the buffer.
// - Selector 01 pulses the transmit event once the last character is fully shifted out.
// - Selector 00 pulses the transmit event on every load into the shifter.
// - With infrared off the line idles low when inverted and high otherwise.
// - With infrared on the encoded line idles high when inverted and low otherwise.
// - A break request sends a start bit, twelve zero bits and a stop bit next.
// - Hardware clears the break request when the break frame has been sent.
// - The transmitter owns the pin while enabled and hands it back when disabled.
// - Disabling transmit aborts the frame in flight and empties the buffer.
// - The read-only buffer-full flag shows that no slot is free.
// - The shifter-empty flag is set only when shifter and buffer are both empty.
// - The shifter-empty flag is low while a character shifts or waits, and ignores writes.
// - Receive selector 11 pulses the receive event when a transfer makes four characters.
// - Receive selector 10 pulses the receive event when a transfer makes three characters.
// - Receive selector 00 or 01 pulses the receive event on every transfer.
//
// Implementation choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "usc_defines.svh"

module usc_top
  import usc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Avalon-MM slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Serial line
  output logic             serial_tx_pin,
  output logic             serial_tx_oe,
  input  wire logic        serial_rx_pin,
  // Event pulses
  output logic             tx_irq,
  output logic             rx_irq
);

  // Bus handshake
  logic             ack_ff;
  logic [31:0]      readdata_ff;
  logic             wr_acc;
  logic             rd_acc;
  logic             sel_stat;
  logic             sel_tx;
  logic             sel_rx;
  logic             sel_cfg;
  logic             wr_hi;
  logic             wr_lo;
  // Control fields
  logic [1:0]       tx_irq_select_ff;
  logic             tx_idle_invert_ff;
  logic             tx_break_request_ff;
  logic             tx_enable_bit_ff;
  logic [1:0]       rx_irq_select_ff;
  logic             address_detect_enable_ff;
  logic             overrun_error_flag_ff;
  logic             infrared_encode_enable_ff;
  logic [15:0]      baud_div_ff;
  // Status
  logic             tx_buffer_full;
  logic             tx_shifter_empty;
  logic             rx_idle_flag;
  logic             framing_error_flag;
  logic             parity_error_flag;
  logic             rx_data_available;
  logic [15:0]      stat_word;
  // Transmit path
  usc_tx_state_type tx_state_ff;
  logic [13:0]      tx_shift_register_ff;
  logic [3:0]       tx_left_ff;
  logic [15:0]      tx_baud_ff;
  logic             tx_is_brk_ff;
  logic             tx_push;
  logic             tx_load;
  logic             tx_tick;
  logic             tx_done;
  logic             tx_bit;
  logic             ir_pulse;
  logic [7:0]       txq_head;
  logic [2:0]       txq_count;
  logic             txq_full;
  logic             txq_empty;
  logic             serial_tx_pin_ff;
  logic             serial_tx_oe_ff;
  logic             tx_irq_ff;
  logic             nxt_tx_irq;
  // Receive path
  usc_rx_state_type rx_state_ff;
  logic [15:0]      rx_baud_ff;
  logic [2:0]       rx_bits_ff;
  logic [7:0]       rx_shift_register_ff;
  logic             rx_frame_done;
  logic             rx_push;
  logic             rx_pop;
  logic             rx_overrun;
  logic [8:0]       rxq_head;
  logic [2:0]       rxq_count;
  logic [2:0]       rxq_next_cnt;
  logic             rxq_full;
  logic             rxq_empty;
  logic             rx_irq_ff;
  logic             nxt_rx_irq;

  // Address decode and accept strobes; every access takes one wait cycle
  assign sel_stat    = (address == `USC_OFS_STAT);
  assign sel_tx      = (address == `USC_OFS_TXDATA);
  assign sel_rx      = (address == `USC_OFS_RXDATA);
  assign sel_cfg     = (address == `USC_OFS_CFG);
  assign wr_acc      = write & ack_ff;
  assign rd_acc      = read & ack_ff;
  assign wr_hi       = wr_acc & sel_stat & byteenable[1];
  assign wr_lo       = wr_acc & sel_stat & byteenable[0];
  assign waitrequest = (read | write) & ~ack_ff;
  assign readdata    = readdata_ff;

  // Acknowledge one cycle after the request appears
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (read | write) & ~ack_ff;
    end
  end

  // Read data captured in the wait cycle; unmapped offsets read zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      readdata_ff <= `USC_RDATA_RST;
    end else if (read && !ack_ff) begin
      if (sel_stat) begin
        readdata_ff <= {16'h0000, stat_word};
      end else if (sel_rx) begin
        readdata_ff <= {23'h00_0000, rxq_head};
      end else if (sel_cfg) begin
        readdata_ff <= {15'h0000, infrared_encode_enable_ff, baud_div_ff};
      end else begin
        readdata_ff <= `USC_RDATA_RST;
      end
    end
  end

  // Status word; flags other than overrun are computed, so writes cannot touch them
  assign tx_buffer_full     = txq_full;
  assign tx_shifter_empty   = (tx_state_ff == USC_TX_IDLE) & txq_empty;
  assign rx_idle_flag       = (rx_state_ff == USC_RX_IDLE);
  assign framing_error_flag = rxq_head[8] & ~rxq_empty;
  assign parity_error_flag  = 1'b0;
  assign rx_data_available  = ~rxq_empty;
  assign stat_word = {tx_irq_select_ff[1], tx_idle_invert_ff, tx_irq_select_ff[0], 1'b0,
                      tx_break_request_ff, tx_enable_bit_ff, tx_buffer_full,
                      tx_shifter_empty, rx_irq_select_ff, address_detect_enable_ff,
                      rx_idle_flag, parity_error_flag, framing_error_flag,
                      overrun_error_flag_ff, rx_data_available};

  // Writable control fields of the status/control register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_irq_select_ff         <= 2'b00;
      tx_idle_invert_ff        <= 1'b0;
      tx_enable_bit_ff         <= 1'b0;
      rx_irq_select_ff         <= 2'b00;
      address_detect_enable_ff <= 1'b0;
    end else begin
      if (wr_hi) begin
        tx_irq_select_ff  <= {writedata[`USC_B_TXISEL1], writedata[`USC_B_TXISEL0]};
        tx_idle_invert_ff <= writedata[`USC_B_TXINV];
        tx_enable_bit_ff  <= writedata[`USC_B_TXEN];
      end
      if (wr_lo) begin
        rx_irq_select_ff         <= {writedata[`USC_B_RXISEL1], writedata[`USC_B_RXISEL0]};
        address_detect_enable_ff <= writedata[`USC_B_ADDRESS_DETECT_ENABLE];
      end
    end
  end

  // Break request: software write wins, hardware clears at frame end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_break_request_ff <= 1'b0;
    end else if (wr_hi) begin
      tx_break_request_ff <= writedata[`USC_B_TXBRK];
    end else if (tx_done && tx_is_brk_ff) begin
      tx_break_request_ff <= 1'b0;
    end
  end

  // Overrun flag: a new overrun wins over a clearing write
  always_ff @(posedge clk) begin
    if (!rstn) begin
      overrun_error_flag_ff <= 1'b0;
    end else if (rx_overrun) begin
      overrun_error_flag_ff <= 1'b1;
    end else if (wr_lo && !writedata[`USC_B_OVERRUN_ERROR_FLAG]) begin
      overrun_error_flag_ff <= 1'b0;
    end
  end

  // Configuration: baud divisor and infrared encoder enable
  always_ff @(posedge clk) begin
    if (!rstn) begin
      baud_div_ff               <= `USC_DIV_RST;
      infrared_encode_enable_ff <= 1'b0;
    end else if (wr_acc && sel_cfg) begin
      if (byteenable[0]) begin
        baud_div_ff[7:0] <= writedata[7:0];
      end
      if (byteenable[1]) begin
        baud_div_ff[15:8] <= writedata[15:8];
      end
      if (byteenable[2]) begin
        infrared_encode_enable_ff <= writedata[`USC_B_INFRARED_ENCODE_ENABLE];
      end
    end
  end

  // Transmit buffer; held empty while transmit is disabled
  assign tx_push = wr_acc & sel_tx & byteenable[0] & tx_enable_bit_ff & ~txq_full;

  usc_fifo #(
    .WIDTH (8)
  ) u_txq (
    .clk   (clk),
    .rstn  (rstn),
    .flush (~tx_enable_bit_ff),
    .push  (tx_push),
    .din   (writedata[7:0]),
    .pop   (tx_load),
    .dout  (txq_head),
    .count (txq_count),
    .full  (txq_full),
    .empty (txq_empty)
  );

  // Transmit engine strobes
  assign tx_load = tx_enable_bit_ff & (tx_state_ff == USC_TX_IDLE) & ~txq_empty;
  assign tx_tick = (tx_baud_ff == baud_div_ff);
  assign tx_done = (tx_state_ff == USC_TX_SHIFT) & tx_tick & (tx_left_ff == 4'h1);

  // Shifter: data frame or break frame, LSB first, one bit per baud period
  always_ff @(posedge clk) begin
    if (!rstn || !tx_enable_bit_ff) begin
      tx_state_ff          <= USC_TX_IDLE;
      tx_shift_register_ff <= 14'h3FFF;
      tx_left_ff           <= 4'h0;
      tx_baud_ff           <= 16'h0000;
      tx_is_brk_ff         <= 1'b0;
    end else begin
      case (tx_state_ff)
        USC_TX_IDLE: begin
          if (tx_load) begin
            tx_state_ff  <= USC_TX_SHIFT;
            tx_baud_ff   <= 16'h0000;
            tx_is_brk_ff <= tx_break_request_ff;
            if (tx_break_request_ff) begin
              tx_shift_register_ff <= {1'b1, 12'h000, 1'b0};
              tx_left_ff           <= `USC_BRK_FRAME;
            end else begin
              tx_shift_register_ff <= {4'hF, 1'b1, txq_head, 1'b0};
              tx_left_ff           <= `USC_DATA_FRAME;
            end
          end
        end
        USC_TX_SHIFT: begin
          if (tx_tick) begin
            tx_baud_ff           <= 16'h0000;
            tx_shift_register_ff <= {1'b1, tx_shift_register_ff[13:1]};
            tx_left_ff           <= tx_left_ff - 4'h1;
            if (tx_left_ff == 4'h1) begin
              tx_state_ff <= USC_TX_IDLE;
            end
          end else begin
            tx_baud_ff <= tx_baud_ff + 16'h0001;
          end
        end
        default: begin
          tx_state_ff <= USC_TX_IDLE;
        end
      endcase
    end
  end

  // Line level and infrared pulse (zero bits pulse for a quarter period)
  assign tx_bit   = (tx_state_ff == USC_TX_SHIFT) ? tx_shift_register_ff[0] : 1'b1;
  assign ir_pulse = (tx_state_ff == USC_TX_SHIFT) & ~tx_shift_register_ff[0] &
                    (tx_baud_ff < {2'b00, baud_div_ff[15:2]});

  // Registered pin drive and ownership
  always_ff @(posedge clk) begin
    if (!rstn) begin
      serial_tx_pin_ff <= 1'b1;
      serial_tx_oe_ff  <= 1'b0;
    end else begin
      if (infrared_encode_enable_ff) begin
        serial_tx_pin_ff <= ir_pulse ^ tx_idle_invert_ff;
      end else begin
        serial_tx_pin_ff <= tx_bit ^ tx_idle_invert_ff;
      end
      serial_tx_oe_ff <= tx_enable_bit_ff;
    end
  end

  assign serial_tx_pin = serial_tx_pin_ff;
  assign serial_tx_oe  = serial_tx_oe_ff;

  // Transmit event selection
  always_comb begin
    case (tx_irq_select_ff)
      2'b00:   nxt_tx_irq = tx_load;
      2'b10:   nxt_tx_irq = tx_load & (txq_count == 3'h1) & ~tx_push;
      2'b01:   nxt_tx_irq = tx_done & txq_empty;
      default: nxt_tx_irq = 1'b0;
    endcase
  end

  // Receive engine: start found at half period, data sampled each period
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_state_ff          <= USC_RX_IDLE;
      rx_baud_ff           <= 16'h0000;
      rx_bits_ff           <= 3'h0;
      rx_shift_register_ff <= 8'h00;
    end else begin
      case (rx_state_ff)
        USC_RX_IDLE: begin
          rx_baud_ff <= 16'h0000;
          if (!serial_rx_pin) begin
            rx_state_ff <= USC_RX_START;
          end
        end
        USC_RX_START: begin
          if (rx_baud_ff == {1'b0, baud_div_ff[15:1]}) begin
            rx_baud_ff  <= 16'h0000;
            rx_bits_ff  <= 3'h0;
            rx_state_ff <= serial_rx_pin ? USC_RX_IDLE : USC_RX_DATA;
          end else begin
            rx_baud_ff <= rx_baud_ff + 16'h0001;
          end
        end
        USC_RX_DATA: begin
          if (rx_baud_ff == baud_div_ff) begin
            rx_baud_ff           <= 16'h0000;
            rx_shift_register_ff <= {serial_rx_pin, rx_shift_register_ff[7:1]};
            rx_bits_ff           <= rx_bits_ff + 3'h1;
            if (rx_bits_ff == `USC_RX_LAST_BIT) begin
              rx_state_ff <= USC_RX_STOP;
            end
          end else begin
            rx_baud_ff <= rx_baud_ff + 16'h0001;
          end
        end
        USC_RX_STOP: begin
          if (rx_baud_ff == baud_div_ff) begin
            rx_state_ff <= USC_RX_IDLE;
          end else begin
            rx_baud_ff <= rx_baud_ff + 16'h0001;
          end
        end
        default: begin
          rx_state_ff <= USC_RX_IDLE;
        end
      endcase
    end
  end

  // Transfer into the receive buffer; dropped while full or overrun stands
  assign rx_frame_done = (rx_state_ff == USC_RX_STOP) & (rx_baud_ff == baud_div_ff);
  assign rx_push       = rx_frame_done & ~rxq_full & ~overrun_error_flag_ff;
  assign rx_overrun    = rx_frame_done & rxq_full;
  assign rx_pop        = rd_acc & sel_rx & ~rxq_empty;
  assign rxq_next_cnt  = rxq_count + 3'h1 - {2'b00, rx_pop};

  usc_fifo #(
    .WIDTH (9)
  ) u_rxq (
    .clk   (clk),
    .rstn  (rstn),
    .flush (1'b0),
    .push  (rx_push),
    .din   ({~serial_rx_pin, rx_shift_register_ff}),
    .pop   (rx_pop),
    .dout  (rxq_head),
    .count (rxq_count),
    .full  (rxq_full),
    .empty (rxq_empty)
  );

  // Receive event selection
  always_comb begin
    case (rx_irq_select_ff)
      2'b11:   nxt_rx_irq = rx_push & (rxq_next_cnt == 3'h4);
      2'b10:   nxt_rx_irq = rx_push & (rxq_next_cnt == 3'h3);
      default: nxt_rx_irq = rx_push;
    endcase
  end

  // Registered event pulses
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_irq_ff <= 1'b0;
      rx_irq_ff <= 1'b0;
    end else begin
      tx_irq_ff <= nxt_tx_irq;
      rx_irq_ff <= nxt_rx_irq;
    end
  end

  assign tx_irq = tx_irq_ff;
  assign rx_irq = rx_irq_ff;

endmodule : usc_top
